// [verilog/sadc_defs.svh]
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

`define SADC_CLK_MHZ       200
`define SADC_RES_BITS      14
`define SADC_TAG_BITS      6
`define SADC_FRAME_BITS    20
`define SADC_MAX_EXTRA     6

// Conversion interval limits in ns, rounded down to whole cycles
`define SADC_CONV_BYP_NS   660
`define SADC_CONV_PGA_NS   1550
`define SADC_CONV_BYP_CYC  ((`SADC_CONV_BYP_NS*`SADC_CLK_MHZ)/1000)
`define SADC_CONV_PGA_CYC  ((`SADC_CONV_PGA_NS*`SADC_CLK_MHZ)/1000)
`define SADC_STEP_BYP_CYC  (`SADC_CONV_BYP_CYC/`SADC_RES_BITS)
`define SADC_STEP_PGA_CYC  (`SADC_CONV_PGA_CYC/`SADC_RES_BITS)

// Least start-line high time in ns, rounded up to whole cycles
`define SADC_CSH_NS        150
`define SADC_CSH_LP_NS     500
`define SADC_CSH_CYC       ((`SADC_CSH_NS*`SADC_CLK_MHZ+999)/1000)
`define SADC_CSH_LP_CYC    ((`SADC_CSH_LP_NS*`SADC_CLK_MHZ+999)/1000)

// Serial clock half period in cycles: 80 ns period, under 50 MHz
`define SADC_SCLK_HALF     8

// Host register byte addresses
`define SADC_ADR_CTRL      8'h00
`define SADC_ADR_STATUS    8'h04
`define SADC_ADR_DATA      8'h08

// Control register fields
`define SADC_CTRL_CH_LSB   0
`define SADC_CTRL_GAIN_LSB 3
`define SADC_CTRL_BYP      6
`define SADC_CTRL_LPS      7
`define SADC_CTRL_PD_N     8
`define SADC_CTRL_XTR_LSB  9
`define SADC_CTRL_START    16
`define SADC_CTRL_RESET    32'h00000140

`endif

// [verilog/sadc_pkg.sv]
package sadc_pkg;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_CONV = 3'b010,
    DEV_READ = 3'b100
  } sadc_dev_st_e;

  typedef enum logic [5:0] {
    HST_IDLE   = 6'b000001,
    HST_CSH    = 6'b000010,
    HST_WAITHI = 6'b000100,
    HST_WAITLO = 6'b001000,
    HST_LOW    = 6'b010000,
    HST_HIGH   = 6'b100000
  } sadc_hst_st_e;

  typedef struct packed {
    sadc_dev_st_e st;
    logic         cs_prev;
    logic         sclk_prev;
    logic [2:0]   ch_lat;
    logic [2:0]   gain_lat;
    logic         byp_lat;
    logic         warm;
    logic         inv;
    logic [13:0]  target;
    logic [13:0]  sar;
    logic [3:0]   bitn;
    logic [4:0]   stepc;
    logic [19:0]  shreg;
    logic         busy;
    logic         sdo;
    logic         sdo_oe;
    logic [13:0]  result;
    logic         result_valid;
    logic         result_invalid;
  } sadc_dev_s;

  typedef struct packed {
    sadc_hst_st_e st;
    logic [31:0]  ctrl;
    logic [6:0]   cnt;
    logic [4:0]   nbits;
    logic [19:0]  shreg;
    logic [19:0]  data;
    logic         done;
    logic         warm;
    logic         suspect;
    logic         cs_n;
    logic         sclk;
    logic         ack;
    logic [31:0]  dat_o;
  } sadc_hst_s;

endpackage

// [verilog/sadc_if.sv]
`timescale 1ns/100ps
interface sadc_if;
  logic       conv_start_n;
  logic       sclk;
  logic       busy;
  logic       sdo;
  logic       sdo_oe;
  logic [2:0] channel_select_pins;
  logic [2:0] gain_select_pins;
  logic       gain_bypass;
  logic       low_power_select;
  logic       power_down_n;

  modport dev (
    input  conv_start_n, sclk, channel_select_pins, gain_select_pins,
           gain_bypass, low_power_select, power_down_n,
    output busy, sdo, sdo_oe
  );

  modport host (
    output conv_start_n, sclk, channel_select_pins, gain_select_pins,
           gain_bypass, low_power_select, power_down_n,
    input  busy, sdo, sdo_oe
  );
endinterface

// [verilog/sadc_sync.sv]
`timescale 1ns/100ps
module sadc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // Resets to ones so an idle high line shows no edge at release
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= '1;
      q        <= '1;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // sadc_sync

// [verilog/sadc_dev.sv]
// Operation
// - Eight-to-one channel mux feeds the converter
// - Channel and gain come only from pins
// - Bypass plus gains 1,2,3,4,6,8,12,16
// - Each result is a 14-bit SAR word
// - Start line fall samples and starts conversion
// - Host holds start high 150/500 ns
// - Own oscillator times every conversion
// - Busy high for whole conversion, then low
// - Host keeps serial clock low while busy
// - MSB on data out when busy falls
// - Each serial rise shifts next lower bit
// - Current conversion read out, no latency
// - Host serial clock at most 50 MHz
// - Host limits rate to 900k/480k samples
// - Data out released while start line high
// - Up to six extra bits: channel, gain
// - Fewer extra edges give fewer tag bits
// - First normal-mode sample after wake invalid
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "sadc_defs.svh"
module sadc_dev (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              ce,
  sadc_if.dev                    lnk,
  input  wire logic [7:0][13:0]  ain,
  output logic      [13:0]       result,
  output logic                   result_valid,
  output logic                   result_invalid
);
  localparam logic [4:0] STEP_BYP = 5'(`SADC_STEP_BYP_CYC);
  localparam logic [4:0] STEP_PGA = 5'(`SADC_STEP_PGA_CYC);

  sadc_pkg::sadc_dev_s r_reg;
  sadc_pkg::sadc_dev_s r_next;

  logic [10:0] pins_s;
  logic        cs_s;
  logic        sclk_s;
  logic [2:0]  ch_s;
  logic [2:0]  gain_s;
  logic        byp_s;
  logic        lps_s;
  logic        pd_n_s;

  // Every pin from the host is foreign to this clock
  sadc_sync #(
    .W (11)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({lnk.conv_start_n, lnk.sclk, lnk.channel_select_pins,
             lnk.gain_select_pins, lnk.gain_bypass, lnk.low_power_select,
             lnk.power_down_n}),
    .q     (pins_s)
  );

  assign cs_s   = pins_s[10];
  assign sclk_s = pins_s[9];
  assign ch_s   = pins_s[8:6];
  assign gain_s = pins_s[5:3];
  assign byp_s  = pins_s[2];
  assign lps_s  = pins_s[1];
  assign pd_n_s = pins_s[0];

  function automatic logic [4:0] gain_of(input logic [2:0] code,
                                         input logic       byp);
    logic [4:0] g;
    g = 5'h01;
    case (code)
      3'h0:    g = 5'h01;
      3'h1:    g = 5'h02;
      3'h2:    g = 5'h03;
      3'h3:    g = 5'h04;
      3'h4:    g = 5'h06;
      3'h5:    g = 5'h08;
      3'h6:    g = 5'h0C;
      3'h7:    g = 5'h10;
      default: g = 5'h01;
    endcase
    if (byp) begin
      g = 5'h01;
    end
    return g;
  endfunction

  // Amplified level clips at full scale rather than wrapping
  function automatic logic [13:0] amplify(input logic [13:0] v,
                                          input logic [4:0]  g);
    logic [18:0] p;
    p = 19'(v) * 19'(g);
    if (p > 19'h03FFF) begin
      return 14'h3FFF;
    end
    return p[13:0];
  endfunction

  logic        cs_fall;
  logic        cs_rise;
  logic        sclk_rise;
  logic [13:0] cand;
  logic [13:0] sar_new;
  logic [4:0]  step_len;

  always_comb begin
    r_next = r_reg;
    r_next.result_valid = 1'b0;
    r_next.cs_prev      = cs_s;
    r_next.sclk_prev    = sclk_s;
    cs_fall   = r_reg.cs_prev & ~cs_s;
    cs_rise   = ~r_reg.cs_prev & cs_s;
    sclk_rise = ~r_reg.sclk_prev & sclk_s;
    cand      = r_reg.sar | (14'h0001 << r_reg.bitn);
    sar_new   = (cand <= r_reg.target) ? cand : r_reg.sar;
    step_len  = r_reg.byp_lat ? STEP_BYP : STEP_PGA;

    if (!pd_n_s) begin
      // Power-down: outputs quiet, wake state lost
      r_next.st     = sadc_pkg::DEV_IDLE;
      r_next.busy   = 1'b0;
      r_next.sdo    = 1'b0;
      r_next.sdo_oe = 1'b0;
      r_next.warm   = 1'b0;
    end else begin
      // Selects follow pins while start is high, frozen at its fall
      if (cs_s) begin
        r_next.ch_lat   = ch_s;
        r_next.gain_lat = gain_s;
        r_next.byp_lat  = byp_s;
      end
      if (cs_rise) begin
        r_next.st     = sadc_pkg::DEV_IDLE;
        r_next.sdo    = 1'b0;
        r_next.sdo_oe = 1'b0;
        r_next.warm   = 1'b1;
      end else begin
        case (r_reg.st)
          sadc_pkg::DEV_IDLE: begin
            r_next.sdo_oe = 1'b0;
            if (cs_fall) begin
              // Sample instant: selected channel through the amplifier
              r_next.target = amplify(ain[r_reg.ch_lat],
                                      gain_of(r_reg.gain_lat,
                                              r_reg.byp_lat));
              r_next.inv    = ~r_reg.warm & ~lps_s;
              r_next.st     = sadc_pkg::DEV_CONV;
              r_next.busy   = 1'b1;
              r_next.sdo    = 1'b0;
              r_next.sdo_oe = 1'b1;
              r_next.sar    = 14'h0000;
              r_next.bitn   = 4'hD;
              r_next.stepc  = 5'h00;
            end
          end
          sadc_pkg::DEV_CONV: begin
            // Step timing from the local clock only; serial clock ignored
            if (r_reg.stepc == step_len - 5'h01) begin
              r_next.stepc = 5'h00;
              r_next.sar   = sar_new;
              r_next.bitn  = r_reg.bitn - 4'h1;
              if (r_reg.bitn == 4'h0) begin
                r_next.st             = sadc_pkg::DEV_READ;
                r_next.busy           = 1'b0;
                r_next.sdo            = sar_new[13];
                r_next.shreg          = {sar_new, r_reg.ch_lat,
                                         r_reg.gain_lat};
                r_next.result         = sar_new;
                r_next.result_valid   = 1'b1;
                r_next.result_invalid = r_reg.inv;
              end
            end else begin
              r_next.stepc = r_reg.stepc + 5'h01;
            end
          end
          sadc_pkg::DEV_READ: begin
            // Host waits for busy low before clocking
            if (sclk_rise) begin
              r_next.shreg = {r_reg.shreg[18:0], 1'b0};
              r_next.sdo   = r_reg.shreg[18];
            end
          end
          default: begin
            r_next.st     = sadc_pkg::DEV_IDLE;
            r_next.busy   = 1'b0;
            r_next.sdo_oe = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r_reg <= '{st: sadc_pkg::DEV_IDLE, cs_prev: 1'b1, sclk_prev: 1'b1,
                 default: '0};
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign lnk.busy       = r_reg.busy;
  assign lnk.sdo        = r_reg.sdo;
  assign lnk.sdo_oe     = r_reg.sdo_oe;
  assign result         = r_reg.result;
  assign result_valid   = r_reg.result_valid;
  assign result_invalid = r_reg.result_invalid;
endmodule // sadc_dev

// [verilog/sadc_host.sv]
`timescale 1ns/100ps
`include "sadc_defs.svh"
module sadc_host (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  sadc_if.host             lnk,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  localparam logic [6:0] CSH    = 7'(`SADC_CSH_CYC);
  localparam logic [6:0] CSH_LP = 7'(`SADC_CSH_LP_CYC);
  localparam logic [6:0] HALF   = 7'(`SADC_SCLK_HALF);

  sadc_pkg::sadc_hst_s r_reg;
  sadc_pkg::sadc_hst_s r_next;
  logic [1:0]          in_s;
  logic                busy_s;
  logic                sdo_s;
  logic                req;
  logic                wr;
  logic [2:0]          xtr;

  sadc_sync #(
    .W (2)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({lnk.busy, lnk.sdo & lnk.sdo_oe}),
    .q     (in_s)
  );
  assign busy_s = in_s[1];
  assign sdo_s  = in_s[0];

  always_comb begin
    r_next = r_reg;
    req    = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    // Write lands at the edge where the master sees ack high
    wr     = wb_cyc_i & wb_stb_i & wb_we_i & r_reg.ack;
    xtr    = r_reg.ctrl[`SADC_CTRL_XTR_LSB +: 3];
    r_next.ack = req;
    r_next.cnt = r_reg.cnt + 7'h01;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        `SADC_ADR_CTRL:   r_next.dat_o = r_reg.ctrl;
        `SADC_ADR_STATUS: r_next.dat_o = {29'h0, r_reg.suspect,
                                          r_reg.done,
                                          r_reg.st != sadc_pkg::HST_IDLE};
        `SADC_ADR_DATA:   r_next.dat_o = {12'h0, r_reg.data};
        default:          r_next.dat_o = 32'h0;
      endcase
    end
    case (r_reg.st)
      sadc_pkg::HST_IDLE: begin
        if (wr && wb_adr_i == `SADC_ADR_CTRL) begin
          // Selects change only while start is high and idle
          if (wb_sel_i[0]) r_next.ctrl[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) r_next.ctrl[15:8] = wb_dat_i[15:8];
          if (wb_sel_i[1] && !wb_dat_i[`SADC_CTRL_PD_N]) begin
            r_next.warm = 1'b0;
          end
          if (wb_sel_i[2] && wb_dat_i[`SADC_CTRL_START]
              && r_reg.ctrl[`SADC_CTRL_PD_N]) begin
            r_next.st   = sadc_pkg::HST_CSH;
            r_next.cnt  = 7'h00;
            r_next.done = 1'b0;
          end
        end
      end
      sadc_pkg::HST_CSH: begin
        // Start high gap before the fall, longer in low power
        if (r_reg.cnt >= (r_reg.ctrl[`SADC_CTRL_LPS] ? CSH_LP : CSH))
        begin
          r_next.cs_n  = 1'b0;
          r_next.st    = sadc_pkg::HST_WAITHI;
          r_next.nbits = 5'(`SADC_RES_BITS) + 5'(xtr > 3'h6 ? 3'h6 : xtr);
        end
      end
      sadc_pkg::HST_WAITHI: begin
        if (busy_s) r_next.st = sadc_pkg::HST_WAITLO;
      end
      sadc_pkg::HST_WAITLO: begin
        // Serial clock stays low until busy is seen low
        if (!busy_s) begin
          r_next.st  = sadc_pkg::HST_LOW;
          r_next.cnt = 7'h00;
        end
      end
      sadc_pkg::HST_LOW: begin
        if (r_reg.cnt == HALF - 7'h01) begin
          r_next.cnt   = 7'h00;
          r_next.shreg = {r_reg.shreg[18:0], sdo_s};
          r_next.nbits = r_reg.nbits - 5'h01;
          if (r_reg.nbits == 5'h01) begin
            r_next.st   = sadc_pkg::HST_IDLE;
            r_next.cs_n = 1'b1;
            r_next.done = 1'b1;
            // Left-align: unread tag bits stay zero at the bottom
            r_next.data = {r_reg.shreg[18:0], sdo_s}
                          << (3'h6 - (xtr > 3'h6 ? 3'h6 : xtr));
            r_next.suspect = ~r_reg.warm & ~r_reg.ctrl[`SADC_CTRL_LPS];
            r_next.warm    = 1'b1;
          end else begin
            r_next.sclk = 1'b1;
            r_next.st   = sadc_pkg::HST_HIGH;
          end
        end
      end
      sadc_pkg::HST_HIGH: begin
        if (r_reg.cnt == HALF - 7'h01) begin
          r_next.cnt  = 7'h00;
          r_next.sclk = 1'b0;
          r_next.st   = sadc_pkg::HST_LOW;
        end
      end
      default: begin
        r_next.st   = sadc_pkg::HST_IDLE;
        r_next.cs_n = 1'b1;
        r_next.sclk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r_reg <= '{st: sadc_pkg::HST_IDLE, ctrl: `SADC_CTRL_RESET,
                 cs_n: 1'b1, default: '0};
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign lnk.conv_start_n        = r_reg.cs_n;
  assign lnk.sclk                = r_reg.sclk;
  assign lnk.channel_select_pins = r_reg.ctrl[`SADC_CTRL_CH_LSB +: 3];
  assign lnk.gain_select_pins    = r_reg.ctrl[`SADC_CTRL_GAIN_LSB +: 3];
  assign lnk.gain_bypass         = r_reg.ctrl[`SADC_CTRL_BYP];
  assign lnk.low_power_select    = r_reg.ctrl[`SADC_CTRL_LPS];
  assign lnk.power_down_n        = r_reg.ctrl[`SADC_CTRL_PD_N];
  assign wb_dat_o                = r_reg.dat_o;
  assign wb_ack_o                = r_reg.ack;
endmodule // sadc_host

// [testbench/sadc_asserts.sv]
`timescale 1ns/100ps
module sadc_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic conv_start_n,
  input wire logic sclk,
  input wire logic busy,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic gain_bypass,
  input wire logic low_power_select,
  input wire logic power_down_n
);
  logic [8:0] busy_cnt_reg;
  logic [7:0] high_cnt_reg;

  // The high-time counter saturates so a long idle never wraps into a false short gap
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_cnt_reg <= 9'h000;
      high_cnt_reg <= 8'h00;
    end else begin
      busy_cnt_reg <= busy ? busy_cnt_reg + 9'h001 : 9'h000;
      if (!conv_start_n) begin
        high_cnt_reg <= 8'h00;
      end else if (high_cnt_reg != 8'hFF) begin
        high_cnt_reg <= high_cnt_reg + 8'h01;
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_start_to_busy: assert property ($fell(conv_start_n) |-> ##[2:4] busy)
    else $error("busy did not follow the start fall");
  a_conv_length: assert property (($fell(busy) && !conv_start_n) |->
    busy_cnt_reg == (gain_bypass ? 9'h07E : 9'h134))
    else $error("conversion length wrong");
  a_busy_sdo_low: assert property (busy |-> sdo_oe && !sdo)
    else $error("data out not driven low while converting");
  a_sclk_quiet: assert property (busy |-> !sclk)
    else $error("serial clock high while converting");
  a_sclk_in_frame: assert property ($rose(sclk) |-> !conv_start_n && !busy)
    else $error("serial clock outside readout");
  a_msb_holds: assert property (($fell(busy) && !conv_start_n) |->
    sdo_oe ##1 $stable(sdo) [*8])
    else $error("first bit not held after busy fall");
  a_bit_on_rise: assert property ((sdo_oe && $past(sdo_oe) && !conv_start_n
    && !$past(conv_start_n) && !busy && !$past(busy) && $changed(sdo))
    |-> sclk && $past(sclk, 3))
    else $error("data out moved without a serial clock rise");
  a_sdo_release: assert property (conv_start_n [*6] |-> !sdo_oe)
    else $error("data out driven while start line high");
  a_start_gap: assert property ($fell(conv_start_n) |->
    high_cnt_reg >= (low_power_select ? 8'h64 : 8'h1E))
    else $error("start line high time too short");
  a_pd_idle: assert property (!power_down_n [*4] |-> !busy)
    else $error("converting while powered down");

  c_frame: cover property ($fell(busy) && !conv_start_n);
  c_low_power: cover property ($fell(conv_start_n) && low_power_select);
  c_power_down: cover property (!power_down_n [*4]);
endmodule // sadc_asserts

// [testbench/sadc_tb.sv]
`timescale 1ns/100ps
module sadc_tb;
  logic             clock;
  logic             rst_n;
  logic             ce;
  logic [7:0][13:0] ain;
  logic [13:0]      result;
  logic             result_valid;
  logic             result_invalid;
  logic             wb_cyc;
  logic             wb_stb;
  logic             wb_we;
  logic [7:0]       wb_adr;
  logic [3:0]       wb_sel;
  logic [31:0]      wb_dat;
  logic [31:0]      wb_rdat;
  logic             wb_ack;
  logic             sclk_q;
  logic [4:0]       mon_cnt;
  logic [19:0]      mon_bits;
  logic [13:0]      cap_res;
  logic [31:0]      r;
  int               n_fail;
  int               checked;
  localparam logic [4:0] GAIN_TAB [8] = '{5'h01, 5'h02, 5'h03, 5'h04,
                                          5'h06, 5'h08, 5'h0C, 5'h10};

  sadc_if lnk ();
  sadc_dev u_sadc_dev (.clock(clock), .rst_n(rst_n), .ce(ce),
    .lnk(lnk.dev), .ain(ain), .result(result),
    .result_valid(result_valid), .result_invalid(result_invalid));
  sadc_host u_sadc_host (.clock(clock), .rst_n(rst_n), .ce(ce),
    .lnk(lnk.host), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  sadc_asserts u_sadc_asserts (.clock(clock), .rst_n(rst_n),
    .conv_start_n(lnk.conv_start_n), .sclk(lnk.sclk), .busy(lnk.busy),
    .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe), .gain_bypass(lnk.gain_bypass),
    .low_power_select(lnk.low_power_select),
    .power_down_n(lnk.power_down_n));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Wire monitor: the bit seen just before each serial rise
  always @(posedge clock) begin
    sclk_q <= lnk.sclk;
    if (lnk.sclk === 1'b1 && sclk_q === 1'b0) begin
      mon_bits <= {mon_bits[18:0], lnk.sdo};
      mon_cnt <= mon_cnt + 5'h01;
    end
    if (result_valid === 1'b1) begin
      cap_res <= result;
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_res(input logic [13:0] got, input logic [13:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Held until the ack edge; one idle cycle follows every transfer
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wdat;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 100);
    rdat = wb_rdat;
    if (n >= 100) n_fail++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic [13:0] exp_res(input logic [13:0] a,
                                          input logic [2:0] g,
                                          input logic byp);
    logic [17:0] p;
    p = {4'h0, a} * {13'h0000, (byp ? 5'h01 : GAIN_TAB[g])};
    return (p > 18'h03FFF) ? 14'h3FFF : p[13:0];
  endfunction

  task automatic run_frame(input logic [2:0] ch, input logic [2:0] g,
                           input logic byp, input logic lps,
                           input logic [2:0] xtr, input logic sus);
    logic [13:0] er;
    logic [5:0]  tag;
    int          k;
    int          n;
    k = (xtr > 3'h6) ? 6 : int'(xtr);
    er = exp_res(ain[ch], g, byp);
    tag = {ch, g} & (6'h3F << (6 - k));
    mon_cnt = 5'h00;
    mon_bits = 20'h00000;
    cap_res = 'x;
    wb_xfer(1'b1, 8'h00, {15'h0000, 1'b1, 4'h0, xtr, 1'b1, lps, byp, g, ch},
            r);
    n = 0;
    do begin
      wb_xfer(1'b0, 8'h04, 32'h00000000, r);
      n++;
    end while (r[1] !== 1'b1 && n < 600);
    chk_word(r, {29'h00000000, sus, 2'b10});
    chk_word({31'h00000000, result_invalid}, {31'h00000000, sus});
    chk_word({27'h0000000, mon_cnt}, 32'(13 + k));
    if (!sus) begin
      wb_xfer(1'b0, 8'h08, 32'h00000000, r);
      chk_word(r, {12'h000, er, tag});
      chk_res(cap_res, er);
      chk_word({12'h000, mon_bits}, {12'h000, {er, ch, g} >> (7 - k)});
    end
    $display("frame ch %0d gain %0d extra %0d done", ch, g, k);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    n_fail = 0;
    checked = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hF;
    wb_dat = 32'h00000000;
    sclk_q = 1'b0;
    mon_cnt = 5'h00;
    mon_bits = 20'h00000;
    cap_res = 14'h0000;
    for (int i = 0; i < 8; i++) begin
      ain[i] = 14'h0155 + 14'(i) * 14'h0233;
    end
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    wb_xfer(1'b0, 8'h00, 32'h00000000, r);
    chk_word(r, 32'h00000140);
    wb_xfer(1'b1, 8'h04, 32'hFFFFFFFF, r);
    wb_xfer(1'b1, 8'h0C, 32'hFFFFFFFF, r);
    wb_xfer(1'b0, 8'h04, 32'h00000000, r);
    chk_word(r, 32'h00000000);
    wb_xfer(1'b0, 8'h0C, 32'h00000000, r);
    chk_word(r, 32'h00000000);
    $display("register test done");
    run_frame(3'h0, 3'h0, 1'b1, 1'b0, 3'h6, 1'b1);
    // Every channel and gain code once, extra field 0 to 7 (7 clips to 6 extra bits); bypass mixed in
    for (int i = 0; i < 8; i++) begin
      run_frame(3'(i), 3'(i), (i % 3) == 0, 1'b0, 3'(i), 1'b0);
    end
    wb_xfer(1'b1, 8'h00, 32'h00000040, r);
    wb_xfer(1'b1, 8'h00, 32'h00010040, r);
    wb_xfer(1'b0, 8'h04, 32'h00000000, r);
    chk_word(r, 32'h00000002);
    // Start is refused while powered down, so wake first
    wb_xfer(1'b1, 8'h00, 32'h00000140, r);
    run_frame(3'h2, 3'h1, 1'b0, 1'b1, 3'h6, 1'b0);
    wb_xfer(1'b1, 8'h00, 32'h00000000, r);
    wb_xfer(1'b0, 8'h04, 32'h00000000, r);
    chk_word(r, 32'h00000002);
    wb_xfer(1'b1, 8'h00, 32'h00000100, r);
    run_frame(3'h5, 3'h3, 1'b1, 1'b0, 3'h3, 1'b1);
    $display("power down test done");
    tally_and_finish();
  end
endmodule // sadc_tb
